// [pkg/low_power_pkg.sv]
// Package for the low-power mode controller: register map, fields, states, timing
package low_power_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WAKE_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_DIVIDER = 8'h08;
	localparam logic [7:0] ADDR_WAIT_STOP_MASK = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_OSC_START = 8'h14;
	// Control register fields
	localparam int CTRL_PSEUDO_STOP = 0;
	localparam int CTRL_FAST_WAKE = 1;
	localparam int CTRL_WAKE_TIMER_EN = 2;
	localparam int CTRL_OSC_ENABLE = 3;
	localparam int CTRL_WIDTH = 4;
	localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 4'h0;
	// Divider limits
	localparam int DIV_WIDTH = 6;
	localparam logic [DIV_WIDTH-1:0] DIV_MAX = 6'h3E;
	localparam logic [DIV_WIDTH-1:0] DIV_RESET = 6'h01;
	// Wake period reset
	localparam int PERIOD_WIDTH = 16;
	localparam logic [PERIOD_WIDTH-1:0] PERIOD_RESET = 16'hFFFF;
	// Stop-as-nop length
	localparam logic [1:0] NOP_CYCLES = 2'h2;
	// Oscillator start-up time and derived count
	localparam int OSC_START_US = 2000;
	localparam int CLK_MHZ = 200;
	localparam int OSC_START_CYCLES = OSC_START_US * CLK_MHZ;
	localparam int OSC_CNT_WIDTH = 20;
	// Status fields
	localparam int STAT_WIDTH = 8;

	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_WAIT = 3'b001,
		ST_STOP = 3'b010,
		ST_PSEUDO = 3'b011,
		ST_OSC_START = 3'b100,
		ST_FAST_RUN = 3'b101,
		ST_NOP = 3'b110
	} mode_t;

	typedef enum logic [1:0] {
		RESUME_NEXT = 2'h0,
		RESUME_NMI_VECTOR = 2'h1,
		RESUME_IRQ_VECTOR = 2'h2,
		RESUME_NONE = 2'h3
	} resume_t;

	// CPU instruction strobes and condition flags
	typedef struct packed {
		logic wait_instruction;
		logic stop_instruction;
		logic stop_disable;
		logic nmi_mask;
		logic irq_mask;
		logic user_state;
	} cpu_req_t;

	// Clock and peripheral gating outputs
	typedef struct packed {
		logic osc_run;
		logic osc_low_amplitude;
		logic cpu_clk_en;
		logic bus_clk_en;
		logic real_time_tick_en;
		logic watchdog_timer_en;
		logic fast_clock_sel;
	} clk_ctl_t;
endpackage : low_power_pkg

// [rtl/low_power_mode_control.sv]
// Chip-level power-mode controller with wake timer and bus clock divider
// How it works
// - Full stop gates the crystal oscillator off, stopping all clocked work except the RC-driven wake timer.
// - Optional wake timer ends full stop after a programmed period.
// - Wake timer counts on the RC oscillator, which runs while crystal stops.
// - Pseudo-stop keeps the crystal running at reduced amplitude.
// - Tick and watchdog stay enabled in pseudo-stop.
// - Wait instruction stacks registers then enters wait mode.
// - Each peripheral has a bit choosing stop or run during wait.
// - Peripherals set to stop in wait halt at once, even mid-byte.
// - Pin direction and output level hold unchanged across wait and stop.
// - Bus clock divider may be rewritten at any time.
// - Divider ratio saturates at 62.
// - Stop instruction stacks registers and aborts most module activity.
// - Stop-disable flag set makes stop a two-cycle no-operation.
// - Stop is ignored in user state.
// - External reset restarts from stop through the normal reset path.
// - Nonmaskable wake with mask set resumes after stop, no vector.
// - Nonmaskable wake with mask clear resumes at its service routine.
// - Maskable wake needs mask clear and the source enabled.
// - Nonmaskable pin is level-sensitive and wakes even when disabled.
// - Pseudo-stop select, sampled at stop, picks pseudo-stop or full stop.
// - Default wake restarts oscillator and runs after start-up completes.
// - Fast-wake select resumes at once on the low-speed PLL clock.
// - Wait stops the CPU and mask-selected peripherals; clock chain keeps running.
//
// Our own choices: the address map and the APB slave port.
module low_power_mode_control
	import low_power_pkg::*;
#(
	parameter int NUM_PERIPH = 8,
	parameter int OSC_START = OSC_START_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic rc_tick,
	input wire logic nonmaskable_interrupt_pin,
	input wire logic irq_pin,
	input wire logic [NUM_PERIPH-1:0] periph_irq,
	input wire logic [NUM_PERIPH-1:0] periph_irq_en,
	input wire logic irq_pin_en,
	input wire low_power_pkg::cpu_req_t cpu_req,
	input wire logic [NUM_PERIPH-1:0] gpio_dir_in,
	input wire logic [NUM_PERIPH-1:0] gpio_out_in,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output low_power_pkg::clk_ctl_t clk_ctl,
	output logic [NUM_PERIPH-1:0] periph_halt,
	output logic stack_regs,
	output logic [DIV_WIDTH-1:0] pll_output_divider,
	output logic [NUM_PERIPH-1:0] gpio_dir,
	output logic [NUM_PERIPH-1:0] gpio_out,
	output low_power_pkg::resume_t resume_kind,
	output logic resume_strobe,
	output low_power_pkg::mode_t mode
);
	import low_power_pkg::*;

	logic [CTRL_WIDTH-1:0] ctrl;
	logic [PERIOD_WIDTH-1:0] wake_period;
	logic [NUM_PERIPH-1:0] wait_stop_mask;
	logic [PERIOD_WIDTH-1:0] wake_count;
	logic [OSC_CNT_WIDTH-1:0] osc_count;
	logic [1:0] nop_count;
	logic wake_timer_hit;
	logic [2:0] rc_sync;
	logic [1:0] nmi_sync;
	logic [1:0] irq_sync;
	logic nmi_level;
	logic irq_level;
	logic rc_edge;
	logic maskable_wake;
	logic stop_allowed;
	logic stopped;
	logic pseudo_latched;
	logic [STAT_WIDTH-1:0] status_word;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	mode_t next_mode;

	// Two-flop synchronisers for pins; RC edge from third stage
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rc_sync <= 3'h0;
			nmi_sync <= 2'h0;
			irq_sync <= 2'h0;
		end else begin
			rc_sync <= {rc_sync[1:0], rc_tick};
			nmi_sync <= {nmi_sync[0], nonmaskable_interrupt_pin};
			irq_sync <= {irq_sync[0], irq_pin};
		end
	end
	assign nmi_level = nmi_sync[1];
	assign irq_level = irq_sync[1];
	assign rc_edge = rc_sync[1] & ~rc_sync[2];

	// Wake decisions
	assign maskable_wake = ~cpu_req.irq_mask & ((irq_level & irq_pin_en) | (|(periph_irq & periph_irq_en)));
	assign stop_allowed = ~cpu_req.stop_disable & ~cpu_req.user_state;
	assign stopped = (mode == ST_STOP) | (mode == ST_PSEUDO);

	// APB decode: zero wait states, error on unmapped address
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		case (paddr)
			ADDR_CTRL, ADDR_WAKE_PERIOD, ADDR_DIVIDER,
			ADDR_WAIT_STOP_MASK, ADDR_STATUS, ADDR_OSC_START: addr_ok = 1'b1;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_ok;

	// Control register writes
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ctrl <= CTRL_RESET;
			wake_period <= PERIOD_RESET;
			wait_stop_mask <= '0;
		end else if (wr_en) begin
			if (paddr == ADDR_CTRL)
				ctrl <= pwdata[CTRL_WIDTH-1:0];
			if (paddr == ADDR_WAKE_PERIOD)
				wake_period <= pwdata[PERIOD_WIDTH-1:0];
			if (paddr == ADDR_WAIT_STOP_MASK)
				wait_stop_mask <= pwdata[NUM_PERIPH-1:0];
		end
	end

	// Divider: writable any time, clamped to the top ratio, zero treated as one
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pll_output_divider <= DIV_RESET;
		end else if (wr_en && paddr == ADDR_DIVIDER) begin
			if (pwdata[31:DIV_WIDTH] != '0 || pwdata[DIV_WIDTH-1:0] > DIV_MAX)
				pll_output_divider <= DIV_MAX;
			else if (pwdata[DIV_WIDTH-1:0] == '0)
				pll_output_divider <= DIV_RESET;
			else
				pll_output_divider <= pwdata[DIV_WIDTH-1:0];
		end
	end

	// Status view of the block's own state
	assign status_word = {nmi_level, irq_level, pseudo_latched, wake_timer_hit, 1'b0, mode};

	// Read data registered in setup phase so it is stable in access phase
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prdata <= '0;
		end else if (rd_en) begin
			case (paddr)
				ADDR_CTRL: prdata <= {{(32-CTRL_WIDTH){1'b0}}, ctrl};
				ADDR_WAKE_PERIOD: prdata <= {{(32-PERIOD_WIDTH){1'b0}}, wake_period};
				ADDR_DIVIDER: prdata <= {{(32-DIV_WIDTH){1'b0}}, pll_output_divider};
				ADDR_WAIT_STOP_MASK: prdata <= {{(32-NUM_PERIPH){1'b0}}, wait_stop_mask};
				ADDR_STATUS: prdata <= {{(32-STAT_WIDTH){1'b0}}, status_word};
				ADDR_OSC_START: prdata <= {{(32-OSC_CNT_WIDTH){1'b0}}, osc_count};
				default: prdata <= '0;
			endcase
		end
	end

	// Wake timer counts RC edges only while in full stop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wake_count <= '0;
			wake_timer_hit <= 1'b0;
		end else if (mode == ST_STOP && ctrl[CTRL_WAKE_TIMER_EN]) begin
			if (rc_edge) begin
				if (wake_count >= wake_period) begin
					wake_count <= '0;
					wake_timer_hit <= 1'b1;
				end else begin
					wake_count <= wake_count + 1'b1;
				end
			end
		end else begin
			wake_count <= '0;
			wake_timer_hit <= 1'b0;
		end
	end

	// Mode sequencing
	always_comb begin
		next_mode = mode;
		case (mode)
			ST_RUN, ST_FAST_RUN: begin
				if (cpu_req.stop_instruction && stop_allowed)
					next_mode = ctrl[CTRL_PSEUDO_STOP] ? ST_PSEUDO : ST_STOP;
				else if (cpu_req.stop_instruction)
					next_mode = ST_NOP;
				else if (cpu_req.wait_instruction)
					next_mode = ST_WAIT;
				else if (mode == ST_FAST_RUN && ctrl[CTRL_OSC_ENABLE])
					next_mode = ST_OSC_START;
			end
			ST_NOP:
				if (nop_count == '0)
					next_mode = ST_RUN;
			ST_WAIT:
				if (nmi_level || maskable_wake)
					next_mode = ST_RUN;
			ST_STOP, ST_PSEUDO:
				if (nmi_level || maskable_wake || wake_timer_hit)
					next_mode = ctrl[CTRL_FAST_WAKE] ? ST_FAST_RUN : ST_OSC_START;
			ST_OSC_START:
				if (osc_count == '0)
					next_mode = ST_RUN;
			default: next_mode = ST_RUN;
		endcase
	end

	// Mode register; external reset returns here from any state
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			mode <= ST_RUN;
		else
			mode <= next_mode;
	end

	// Pseudo-stop choice held for the wake path
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			pseudo_latched <= 1'b0;
		else if (next_mode == ST_PSEUDO && mode != ST_PSEUDO)
			pseudo_latched <= 1'b1;
		else if (next_mode == ST_STOP && mode != ST_STOP)
			pseudo_latched <= 1'b0;
	end

	// Ignored stop burns a fixed two cycles
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			nop_count <= '0;
		else if (next_mode == ST_NOP && mode != ST_NOP)
			nop_count <= NOP_CYCLES - 2'h1;
		else if (nop_count != '0)
			nop_count <= nop_count - 2'h1;
	end

	// Oscillator start-up; pseudo-stop skips most since crystal kept running
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			osc_count <= '0;
		else if (next_mode == ST_OSC_START && mode != ST_OSC_START)
			osc_count <= pseudo_latched ? OSC_CNT_WIDTH'(1) : OSC_CNT_WIDTH'(OSC_START - 1);
		else if (mode == ST_OSC_START && osc_count != '0)
			osc_count <= osc_count - 1'b1;
	end

	// Stacking pulse on any real wait or stop entry
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			stack_regs <= 1'b0;
		else
			stack_regs <= (mode == ST_RUN || mode == ST_FAST_RUN) &&
				(next_mode == ST_WAIT || next_mode == ST_STOP || next_mode == ST_PSEUDO);
	end

	// Resume kind reported as wait or stop is left, ahead of any oscillator start-up
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			resume_kind <= RESUME_NONE;
			resume_strobe <= 1'b0;
		end else if ((mode == ST_WAIT || stopped) && next_mode != mode) begin
			resume_strobe <= 1'b1;
			if (nmi_level)
				resume_kind <= cpu_req.nmi_mask ? RESUME_NEXT : RESUME_NMI_VECTOR;
			else if (maskable_wake)
				resume_kind <= RESUME_IRQ_VECTOR;
			else
				resume_kind <= RESUME_NEXT;
		end else begin
			resume_strobe <= 1'b0;
		end
	end

	// Clock gating and peripheral halts, registered; wake lifts them before fetch
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			clk_ctl <= '{osc_run: 1'b1, osc_low_amplitude: 1'b0, cpu_clk_en: 1'b1, bus_clk_en: 1'b1,
				real_time_tick_en: 1'b1, watchdog_timer_en: 1'b1, fast_clock_sel: 1'b0};
			periph_halt <= '0;
		end else begin
			clk_ctl.osc_run <= (next_mode != ST_STOP) && (next_mode != ST_FAST_RUN);
			clk_ctl.osc_low_amplitude <= next_mode == ST_PSEUDO;
			clk_ctl.cpu_clk_en <= (next_mode == ST_RUN) || (next_mode == ST_FAST_RUN) || (next_mode == ST_NOP);
			clk_ctl.bus_clk_en <= (next_mode != ST_STOP) && (next_mode != ST_PSEUDO) &&
				(next_mode != ST_OSC_START);
			clk_ctl.real_time_tick_en <= (next_mode != ST_STOP) && (next_mode != ST_OSC_START);
			clk_ctl.watchdog_timer_en <= (next_mode != ST_STOP) && (next_mode != ST_OSC_START);
			clk_ctl.fast_clock_sel <= next_mode == ST_FAST_RUN;
			if (next_mode == ST_STOP || next_mode == ST_PSEUDO)
				periph_halt <= '1;
			else if (next_mode == ST_WAIT)
				periph_halt <= wait_stop_mask;
			else
				periph_halt <= '0;
		end
	end

	// Pins follow the CPU only while it runs, so they freeze in wait and stop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			gpio_dir <= '0;
			gpio_out <= '0;
		end else if (mode == ST_RUN || mode == ST_FAST_RUN || mode == ST_NOP) begin
			gpio_dir <= gpio_dir_in;
			gpio_out <= gpio_out_in;
		end
	end
endmodule : low_power_mode_control

// [tb/low_power_far_side.sv]
// Reset circuit, free-running RC oscillator and interrupt pin sources
module low_power_far_side (
	input wire logic clk_sys,
	output logic sys_rst,
	output logic rc_tick,
	output logic nonmaskable_interrupt_pin,
	output logic irq_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		sys_rst = 1'b1;
		rc_tick = 1'b0;
		nonmaskable_interrupt_pin = 1'b0;
		irq_pin = 1'b0;
	end
	// RC oscillator keeps running whatever the crystal does, phase unrelated
	always #37.3 rc_tick = ~rc_tick;
	// Reset pin held for n edges
	task reset_pulse(input int n);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (n) @(posedge clk_sys);
		sys_rst <= 1'b0;
	endtask : reset_pulse
	// Levels, not pulses: the nonmaskable line stays up until lowered
	task set_pins(input logic nmi, input logic irq);
		@(posedge clk_sys);
		nonmaskable_interrupt_pin <= nmi;
		irq_pin <= irq;
	endtask : set_pins
endmodule : low_power_far_side

// [tb/low_power_mode_control_sva.sv]
// Mode, clock gating and pin-hold checks for the power-mode controller
module low_power_mode_control_sva
	import low_power_pkg::*;
#(
	parameter int NUM_PERIPH = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire low_power_pkg::cpu_req_t cpu_req,
	input wire low_power_pkg::clk_ctl_t clk_ctl,
	input wire logic [NUM_PERIPH-1:0] periph_halt,
	input wire logic stack_regs,
	input wire logic [DIV_WIDTH-1:0] pll_output_divider,
	input wire logic [NUM_PERIPH-1:0] gpio_dir,
	input wire logic [NUM_PERIPH-1:0] gpio_out,
	input wire logic resume_strobe,
	input wire low_power_pkg::mode_t mode
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// A stop request the controller samples, and whether it must be ignored
	wire logic take_stop = cpu_req.stop_instruction && mode inside {ST_RUN, ST_FAST_RUN};
	wire logic stop_off = cpu_req.stop_disable || cpu_req.user_state;
	a_stop_osc_off: assert property (mode == ST_STOP |-> !clk_ctl.osc_run && !clk_ctl.bus_clk_en && &periph_halt)
		else $error("clock alive in stop");
	a_pseudo_low_amp: assert property (mode == ST_PSEUDO |-> clk_ctl.osc_run && clk_ctl.osc_low_amplitude
		&& clk_ctl.real_time_tick_en && clk_ctl.watchdog_timer_en) else $error("pseudo-stop clocks wrong");
	a_wait_cpu_only: assert property (mode == ST_WAIT |-> !clk_ctl.cpu_clk_en && clk_ctl.bus_clk_en)
		else $error("wait gating wrong");
	a_stop_stacked: assert property (take_stop && !stop_off |=> stack_regs && mode inside {ST_STOP, ST_PSEUDO})
		else $error("stop not entered");
	a_stop_as_nop: assert property (take_stop && stop_off |=> (mode == ST_NOP && !stack_regs) [*2] ##1 mode == ST_RUN)
		else $error("ignored stop not two cycles");
	a_div_range: assert property (pll_output_divider inside {[6'h01:DIV_MAX]})
		else $error("divider out of range");
	a_pins_frozen: assert property (mode inside {ST_WAIT, ST_STOP, ST_PSEUDO} |=> $stable(gpio_dir) && $stable(gpio_out))
		else $error("pins moved while asleep");
	a_run_released: assert property (mode == ST_RUN |-> clk_ctl.cpu_clk_en && periph_halt == '0)
		else $error("run with halted parts");
	a_wake_strobe: assert property (resume_strobe |-> $past(mode) inside {ST_WAIT, ST_STOP, ST_PSEUDO})
		else $error("strobe without wake");
	// Main scenarios reached
	c_stop: cover property (mode == ST_STOP ##1 mode == ST_OSC_START);
	c_pseudo: cover property (mode == ST_PSEUDO ##1 mode == ST_FAST_RUN);
	c_wait: cover property (mode == ST_WAIT ##1 mode == ST_RUN);
endmodule : low_power_mode_control_sva

bind low_power_mode_control low_power_mode_control_sva #(.NUM_PERIPH(NUM_PERIPH)) chk_u (.clk_sys, .sys_rst,
	.cpu_req, .clk_ctl, .periph_halt, .stack_regs, .pll_output_divider, .gpio_dir, .gpio_out, .resume_strobe, .mode);

// [tb/test_low_power_mode_control.sv]
// Self-checking bench for the power-mode controller
module test_low_power_mode_control;
	import low_power_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int OSC_SIM = 20;
	logic clk_sys = 1'b0;
	logic sys_rst, rc_tick, nonmaskable_interrupt_pin, irq_pin, irq_pin_en, psel, penable, pwrite, pready, pslverr;
	logic stack_regs, resume_strobe, er;
	logic [7:0] periph_irq, periph_irq_en, gpio_dir_in, gpio_out_in, periph_halt, gpio_dir, gpio_out, paddr, m;
	logic [31:0] pwdata, prdata, rd, pwdata_word;
	logic [5:0] pll_output_divider, v;
	logic [15:0] rnd = 16'hF055;
	cpu_req_t cpu_req;
	clk_ctl_t clk_ctl;
	resume_t resume_kind;
	mode_t mode;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	int n;
	always #2.5 clk_sys = ~clk_sys;
	low_power_far_side far_u (.clk_sys, .sys_rst, .rc_tick, .nonmaskable_interrupt_pin, .irq_pin);
	low_power_mode_control #(.OSC_START(OSC_SIM)) dut_u (.clk_sys, .sys_rst, .rc_tick, .nonmaskable_interrupt_pin,
		.irq_pin, .periph_irq, .periph_irq_en, .irq_pin_en, .cpu_req, .gpio_dir_in, .gpio_out_in, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clk_ctl, .periph_halt, .stack_regs, .pll_output_divider,
		.gpio_dir, .gpio_out, .resume_kind, .resume_strobe, .mode);
	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	// Divider saturates at both ends rather than wrapping; any upper bit set means too large
	function logic [31:0] div_exp(input logic [31:0] d);
		return (d[31:6] != 26'h0 || d[5:0] > 6'h3E) ? 32'h3E : (d[5:0] == 6'h00) ? 32'h1 : {26'h0, d[5:0]};
	endfunction : div_exp
	task summarize;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : summarize
	task chk_val(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk_val
	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb
	// Stop (s=1) or wait (s=0) instruction strobe for one cycle
	task pulse(input logic s);
		@(posedge clk_sys);
		cpu_req.stop_instruction <= s;
		cpu_req.wait_instruction <= !s;
		@(posedge clk_sys);
		cpu_req.stop_instruction <= 1'b0;
		cpu_req.wait_instruction <= 1'b0;
		#1;
	endtask : pulse
	task wait_mode(input mode_t w);
		n = 0;
		while (mode !== w && n < 3000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
	endtask : wait_mode
	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			$display("[ERR] %0t timeout", $time);
			summarize;
		end
	end
	initial begin
		cpu_req = '0;
		{psel, penable, pwrite, paddr, pwdata, irq_pin_en} = '0;
		{periph_irq, periph_irq_en, gpio_dir_in, gpio_out_in} = '0;
		far_u.reset_pulse(5);
		apb(1'b0, ADDR_WAKE_PERIOD, 32'h0);
		chk_val(rd, 32'h0000FFFF);
		chk_val(clk_ctl, 32'h5E);
		apb(1'b0, 8'h40, 32'h0);
		chk_val({er, rd[30:0]}, 32'h80000000);
		$display("test reset done");
		// Divider: corners 0, 62, 63 then random words with junk in reserved bits
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			v = (i == 0) ? 6'h00 : (i == 1) ? 6'h3E : (i == 2) ? 6'h3F : rnd[5:0];
			pwdata_word = (i < 3) ? {26'h0, v} : {rnd[15:6], rnd, v};
			apb(1'b1, ADDR_DIVIDER, pwdata_word);
			chk_val(pll_output_divider, div_exp(pwdata_word));
			apb(1'b0, ADDR_DIVIDER, 32'h0);
			chk_val(rd, div_exp(pwdata_word));
		end
		$display("test divider done");
		// Stop ignored when disabled, then in user state
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			cpu_req.stop_disable <= (i == 0);
			cpu_req.user_state <= (i == 1);
			pulse(1'b1);
			chk_val({mode, stack_regs}, {ST_NOP, 1'b0});
			wait_mode(ST_RUN);
			chk_val(n, 2);
		end
		$display("test ignored stop done");
		// Wait: halts by mask, pins frozen, maskable wake held off by the mask flag
		rnd = lfsr(rnd);
		m = rnd[7:0];
		apb(1'b1, ADDR_WAIT_STOP_MASK, {rnd, rnd});
		@(posedge clk_sys);
		{cpu_req.stop_disable, cpu_req.user_state, cpu_req.irq_mask, cpu_req.nmi_mask} <= 4'h3;
		{gpio_dir_in, gpio_out_in} <= rnd;
		pulse(1'b0);
		chk_val({mode, stack_regs, periph_halt}, {ST_WAIT, 1'b1, m});
		@(posedge clk_sys);
		{gpio_dir_in, gpio_out_in} <= ~rnd;
		periph_irq <= 8'h81;
		periph_irq_en <= 8'h80;
		repeat (10) @(posedge clk_sys);
		#1;
		chk_val({mode, gpio_dir, gpio_out}, {ST_WAIT, rnd});
		@(posedge clk_sys);
		cpu_req.irq_mask <= 1'b0;
		wait_mode(ST_RUN);
		chk_val(resume_kind, RESUME_IRQ_VECTOR);
		$display("test wait done");
		// Full stop, nonmaskable wake with its mask set, then clear
		@(posedge clk_sys);
		periph_irq <= 8'h00;
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			cpu_req.nmi_mask <= (i == 0);
			pulse(1'b1);
			chk_val({mode, stack_regs, clk_ctl.osc_run}, {ST_STOP, 2'b10});
			far_u.set_pins(1'b1, 1'b0);
			wait_mode(ST_OSC_START);
			chk_val({resume_kind, clk_ctl.cpu_clk_en}, {(i == 0) ? RESUME_NEXT : RESUME_NMI_VECTOR, 1'b0});
			wait_mode(ST_RUN);
			chk_val(n, OSC_SIM);
			far_u.set_pins(1'b0, 1'b0);
			repeat (4) @(posedge clk_sys);
		end
		$display("test stop done");
		// Pseudo-stop with fast wake from the irq pin
		apb(1'b1, ADDR_CTRL, 32'h3);
		@(posedge clk_sys);
		irq_pin_en <= 1'b1;
		pulse(1'b1);
		chk_val({mode, clk_ctl.osc_run, clk_ctl.osc_low_amplitude}, {ST_PSEUDO, 2'b11});
		far_u.set_pins(1'b0, 1'b1);
		wait_mode(ST_FAST_RUN);
		repeat (50) @(posedge clk_sys);
		#1;
		chk_val({mode, clk_ctl.fast_clock_sel}, {ST_FAST_RUN, 1'b1});
		far_u.set_pins(1'b0, 1'b0);
		apb(1'b1, ADDR_CTRL, 32'h8);
		wait_mode(ST_RUN);
		// Timer wake from full stop after period+1 RC edges
		apb(1'b1, ADDR_WAKE_PERIOD, 32'h3);
		apb(1'b1, ADDR_CTRL, 32'h4);
		pulse(1'b1);
		wait_mode(ST_OSC_START);
		chk_val({resume_kind, n > 40 && n < 80}, {RESUME_NEXT, 1'b1});
		wait_mode(ST_RUN);
		// Reset pin ends a stop
		apb(1'b1, ADDR_CTRL, 32'h0);
		pulse(1'b1);
		far_u.reset_pulse(3);
		#1;
		chk_val({mode, resume_kind}, {ST_RUN, RESUME_NONE});
		$display("test wake sources done");
		summarize;
	end
endmodule : test_low_power_mode_control
